// ===== core/slbm_dev.sv
/*
  slbm_dev: converter end of the byte-mode link. holds the link settings,
  checks them against the supported set, decimates the sample stream and
  spreads 8-bit words over the lanes through a two-entry buffer.
  assumes: one converter sample per clock on the user side; the host
  end writes the settings over the register path of slbm_if.
*/
`timescale 1ns/1ps
module slbm_dev
    import slbm_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // link
    slbm_if.dev             lk,
    // converter samples
    input  wire logic       sample_valid,
    input  wire logic [7:0] sample_data,
    input  wire logic       sample_ctrl,
    output logic            sample_ready,
    // status
    output logic            config_error
);
    // ==========================================================
    // settings
    logic [7:0] pll_q, lanes_q, conv_q, opf_q, fmf_q, dcm_q, ctl_q, res_q;
    logic [1:0] band_q;
    logic [7:0] rdata_q;
    logic       cfg_ok_q;
    logic       running;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pll_q   <= RST_PLL_LANE_RATE;
            lanes_q <= RST_LANES;
            conv_q  <= RST_CONVERTERS;
            opf_q   <= RST_OCTETS_FRAME;
            fmf_q   <= RST_FRAMES_MF;
            dcm_q   <= RST_DECIMATION;
            band_q  <= BAND_6G75_13G5;
            ctl_q   <= RST_CONTROL;
            res_q   <= RST_RESOLUTION;
        end
        else if (lk.cfg_wr)
        begin
            unique case (lk.cfg_addr)
                OFS_PLL_LANE_RATE: pll_q   <= lk.cfg_wdata;
                OFS_LANES:         lanes_q <= lk.cfg_wdata;
                OFS_CONVERTERS:    conv_q  <= lk.cfg_wdata;
                OFS_OCTETS_FRAME:  opf_q   <= lk.cfg_wdata;
                OFS_FRAMES_MF:     fmf_q   <= lk.cfg_wdata;
                OFS_DECIMATION:    dcm_q   <= lk.cfg_wdata;
                OFS_BAND:          band_q  <= lk.cfg_wdata[1:0];
                OFS_CONTROL:       ctl_q   <= lk.cfg_wdata;
                OFS_RESOLUTION:    res_q   <= lk.cfg_wdata;
                default:           ;
            endcase
        end
    end

    // unmapped reads answer zero; data stands only the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (srst)
            rdata_q <= 8'h00;
        else if (lk.cfg_rd)
        begin
            unique case (lk.cfg_addr)
                OFS_PLL_LANE_RATE: rdata_q <= pll_q;
                OFS_LANES:         rdata_q <= lanes_q;
                OFS_CONVERTERS:    rdata_q <= conv_q;
                OFS_OCTETS_FRAME:  rdata_q <= opf_q;
                OFS_FRAMES_MF:     rdata_q <= fmf_q;
                OFS_DECIMATION:    rdata_q <= dcm_q;
                OFS_BAND:          rdata_q <= {6'h00, band_q};
                OFS_CONTROL:       rdata_q <= ctl_q;
                OFS_RESOLUTION:    rdata_q <= res_q;
                OFS_STATUS:        rdata_q <= {6'h00, running, cfg_ok_q};
                default:           rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end
    assign lk.cfg_rdata = rdata_q;

    // ==========================================================
    // legality of the programmed set
    function automatic logic [13:0] ratio_bit(input logic [7:0] d);
        // supported ratios as one-hot over 1,2,3,4,5,6,8,10,12,15,16,20,24,30
        unique case (d)
            8'd1:    return 14'h0001;
            8'd2:    return 14'h0002;
            8'd3:    return 14'h0004;
            8'd4:    return 14'h0008;
            8'd5:    return 14'h0010;
            8'd6:    return 14'h0020;
            8'd8:    return 14'h0040;
            8'd10:   return 14'h0080;
            8'd12:   return 14'h0100;
            8'd15:   return 14'h0200;
            8'd16:   return 14'h0400;
            8'd20:   return 14'h0800;
            8'd24:   return 14'h1000;
            8'd30:   return 14'h2000;
            default: return 14'h0000;
        endcase
    endfunction : ratio_bit

    function automatic logic [13:0] ratio_mask(input logic [7:0] m, input logic [7:0] l,
                                               input logic [1:0] b);
        logic [55:0] row;
        row = 56'h0;
        unique case ({m[1:0], l[2:0]})
            {2'd1, 3'd1}: row = {14'h0003, 14'h000f, 14'h007f, 14'h01ff};
            {2'd1, 3'd2}: row = {14'h0001, 14'h0003, 14'h000f, 14'h007f};
            {2'd1, 3'd4}: row = {14'h0000, 14'h0001, 14'h0003, 14'h000f};
            {2'd2, 3'd1}: row = {14'h000f, 14'h007f, 14'h07ff, 14'h3ffa};
            {2'd2, 3'd2}: row = {14'h0003, 14'h000f, 14'h007f, 14'h07ff};
            {2'd2, 3'd4}: row = {14'h0001, 14'h0003, 14'h000f, 14'h007f};
            default:      row = 56'h0;
        endcase
        if (m[7:2] != 6'h00 || l[7:3] != 5'h00)
            row = 56'h0;
        return row[b*14 +: 14];
    endfunction : ratio_mask

    function automatic logic set_listed(input logic [7:0] m, input logic [7:0] l,
                                        input logic [7:0] f);
        unique case ({m, l, f})
            {8'd1, 8'd1, 8'd1}, {8'd1, 8'd1, 8'd2}, {8'd1, 8'd2, 8'd1},
            {8'd1, 8'd2, 8'd2}, {8'd1, 8'd2, 8'd4}, {8'd1, 8'd4, 8'd1},
            {8'd1, 8'd4, 8'd2}, {8'd2, 8'd1, 8'd2}, {8'd2, 8'd2, 8'd1},
            {8'd2, 8'd2, 8'd2}, {8'd2, 8'd4, 8'd1}, {8'd2, 8'd4, 8'd2},
            {8'd2, 8'd4, 8'd4}: return 1'b1;
            default:            return 1'b0;
        endcase
    endfunction : set_listed

    function automatic logic lcm_ok(input logic [7:0] m, input logic [7:0] l,
                                    input logic [7:0] d);
        // 20*ratio*fout/lane rate reduces to 2*ratio*lanes/converters
        logic [15:0] num;
        logic [15:0] a;
        logic        hit;
        num = 16'(2 * d * l);
        a   = 16'h0;
        hit = 1'b0;
        if (m != 8'h00 && num % 16'(m) == 16'h0)
            a = num / 16'(m);
        for (int i = 1; i <= LCM_LIMIT; i++)
        begin
            if (a != 16'h0 && d != 8'h00 && 16'(i) % a == 16'h0 && 8'(i) % d == 8'h00)
                hit = 1'b1;
        end
        return hit;
    endfunction : lcm_ok

    logic       pll_ok, fmf_ok, slr_ok, res_ok, cfg_ok;
    logic [7:0] fmf_min;

    always_comb
    begin
        unique case (band_q)
            BAND_13G5_16G:     pll_ok = (pll_q == PLL_CODE_HIGH);
            BAND_6G75_13G5:    pll_ok = (pll_q == PLL_CODE_MID);
            BAND_3G375_6G75:   pll_ok = (pll_q == PLL_CODE_MID);
            BAND_1G6875_3G375: pll_ok = (pll_q == PLL_CODE_LOW) || (pll_q == PLL_CODE_MID);
        endcase
    end

    // least K per octet count; larger F are not reachable here
    always_comb
    begin
        unique case (opf_q)
            8'd1:    fmf_min = 8'd20;
            8'd2:    fmf_min = 8'd12;
            8'd4:    fmf_min = 8'd8;
            default: fmf_min = 8'd4;
        endcase
    end
    assign fmf_ok = (fmf_q % 8'(FMF_STEP) == 8'h00) && fmf_q >= fmf_min
                    && fmf_q <= 8'(FMF_MAX);
    // lane rate over 40 within sample rate: 10*m*fout/l/40 <= dcm*fout
    assign slr_ok = 16'(LANE_RATE_MULT * conv_q)
                    <= 16'(SLR_DIV * dcm_q * lanes_q);
    assign res_ok = res_q == 8'(WORD_BITS) || res_q == 8'(WORD_BITS - 1);
    assign cfg_ok = set_listed(conv_q, lanes_q, opf_q)
                    && (ratio_mask(conv_q, lanes_q, band_q) & ratio_bit(dcm_q)) != 14'h0
                    && lcm_ok(conv_q, lanes_q, dcm_q)
                    && pll_ok && fmf_ok && slr_ok && res_ok;

    always_ff @(posedge clock)
    begin
        if (srst)
            cfg_ok_q <= 1'b0;
        else
            cfg_ok_q <= cfg_ok;
    end
    // an illegal set never starts the link
    assign running      = ctl_q[CTL_LINK_EN] && cfg_ok_q;
    assign config_error = !cfg_ok_q;

    // ==========================================================
    // decimation: one output word every dcm converter samples
    logic [7:0] dec_cnt_q;
    logic       dec_tick;
    logic       buf_in_ready;
    logic [7:0] word;

    assign dec_tick = (dec_cnt_q == 8'h00);
    always_ff @(posedge clock)
    begin
        if (srst || !running)
            dec_cnt_q <= 8'h00;
        // count only accepted samples so a stalled tick sample is not skipped
        else if (sample_valid && sample_ready)
            dec_cnt_q <= (dec_cnt_q + 8'h01 >= dcm_q) ? 8'h00 : dec_cnt_q + 8'h01;
    end
    // a stalled buffer holds the converter on the decimated sample
    assign sample_ready = running && (!dec_tick || buf_in_ready);

    // 7-bit resolution clears the spare bit unless it carries control
    always_comb
    begin
        word = sample_data;
        if (ctl_q[CTL_CS_EN])
            word[0] = sample_ctrl;
        else if (res_q != 8'(WORD_BITS))
            word[0] = 1'b0;
    end

    // ==========================================================
    // two-entry buffer toward the link
    logic [7:0] mem_q [BUF_DEPTH];
    logic       wr_ptr_q, rd_ptr_q;
    logic [1:0] count_q;
    logic       push, pop;

    assign buf_in_ready = (count_q != 2'(BUF_DEPTH));
    assign push         = running && sample_valid && dec_tick && buf_in_ready;
    assign pop          = lk.lk_valid && lk.lk_ready;
    assign lk.lk_valid  = (count_q != 2'h0);
    assign lk.lk_octet  = mem_q[rd_ptr_q];

    always_ff @(posedge clock)
    begin
        if (push)
            mem_q[wr_ptr_q] <= word;
    end

    always_ff @(posedge clock)
    begin
        if (srst || !running)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q  <= count_q + 2'(push) - 2'(pop);
        end
    end

    // ==========================================================
    // lane, frame and multiframe position of the outgoing word
    logic [1:0] lane_q;
    logic [7:0] oct_q, frame_q;

    always_ff @(posedge clock)
    begin
        if (srst || !running)
        begin
            lane_q  <= 2'h0;
            oct_q   <= 8'h00;
            frame_q <= 8'h00;
        end
        else if (pop)
        begin
            // words go round the lanes; each lane carries its own frame
            lane_q <= (3'(lane_q) + 3'h1 >= lanes_q[2:0]) ? 2'h0 : lane_q + 2'h1;
            if (3'(lane_q) + 3'h1 >= lanes_q[2:0])
            begin
                oct_q <= (oct_q + 8'h01 >= opf_q) ? 8'h00 : oct_q + 8'h01;
                if (oct_q + 8'h01 >= opf_q)
                    frame_q <= (frame_q + 8'h01 >= fmf_q) ? 8'h00 : frame_q + 8'h01;
            end
        end
    end
    assign lk.lk_lane        = lane_q;
    assign lk.lk_frame_start = (oct_q == 8'h00);
    assign lk.lk_mf_start    = (oct_q == 8'h00) && (frame_q == 8'h00);
endmodule : slbm_dev

// ===== core/slbm_pkg.sv
/*
  slbm_pkg: register offsets, reset values, lane-rate band codes and link
  constants shared by the device end and the host end of the byte-mode link.
  assumes: 8-bit register data, 16-bit register addresses.
*/
package slbm_pkg;
    // ==========================================================
    // register map
    localparam logic [15:0] OFS_PLL_LANE_RATE = 16'h056e;
    localparam logic [15:0] OFS_LANES         = 16'h0580;
    localparam logic [15:0] OFS_CONVERTERS    = 16'h0581;
    localparam logic [15:0] OFS_OCTETS_FRAME  = 16'h0582;
    localparam logic [15:0] OFS_FRAMES_MF     = 16'h0583;
    localparam logic [15:0] OFS_DECIMATION    = 16'h0584;
    localparam logic [15:0] OFS_BAND          = 16'h0585;
    localparam logic [15:0] OFS_CONTROL       = 16'h0586;
    localparam logic [15:0] OFS_STATUS        = 16'h0587;
    localparam logic [15:0] OFS_RESOLUTION    = 16'h0588;
    localparam logic [15:0] OFS_HOST_CNT_LO   = 16'h8000;
    localparam logic [15:0] OFS_HOST_CNT_HI   = 16'h8001;
    localparam int          HOST_SPACE_BIT    = 15;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PLL_LANE_RATE = 8'h10;
    localparam logic [7:0] RST_LANES         = 8'h01;
    localparam logic [7:0] RST_CONVERTERS    = 8'h01;
    localparam logic [7:0] RST_OCTETS_FRAME  = 8'h01;
    localparam logic [7:0] RST_FRAMES_MF     = 8'h20;
    localparam logic [7:0] RST_DECIMATION    = 8'h01;
    localparam logic [7:0] RST_CONTROL       = 8'h00;
    localparam logic [7:0] RST_RESOLUTION    = 8'h08;

    // ==========================================================
    // field positions
    localparam int CTL_LINK_EN  = 0;
    localparam int CTL_CS_EN    = 1;
    localparam int STS_CFG_OK   = 0;
    localparam int STS_RUNNING  = 1;

    // ==========================================================
    // lane-rate bands and link pll codes
    typedef enum logic [1:0] {
        BAND_1G6875_3G375 = 2'b00,
        BAND_3G375_6G75   = 2'b01,
        BAND_6G75_13G5    = 2'b10,
        BAND_13G5_16G     = 2'b11
    } slbm_band_t;
    localparam logic [7:0] PLL_CODE_HIGH = 8'h30;
    localparam logic [7:0] PLL_CODE_MID  = 8'h10;
    localparam logic [7:0] PLL_CODE_LOW  = 8'h50;

    // ==========================================================
    // transport constants
    localparam int WORD_BITS      = 8;
    localparam int LANE_RATE_MULT = 10;
    localparam int LCM_LIMIT      = 64;
    localparam int FMF_STEP       = 4;
    localparam int FMF_MAX        = 32;
    localparam int SLR_DIV        = 40;
    localparam int BUF_DEPTH      = 2;
endpackage : slbm_pkg

// ===== core/slbm_if.sv
/*
  slbm_if: the byte-mode link between converter end and receiver end:
  a register path and an octet stream with lane and frame markers.
  assumes: both ends share clock; the testbench joins them.
*/
`timescale 1ns/1ps
interface slbm_if;
    // register path
    logic        cfg_wr;
    logic        cfg_rd;
    logic [15:0] cfg_addr;
    logic [7:0]  cfg_wdata;
    logic [7:0]  cfg_rdata;
    // octet stream
    logic        lk_valid;
    logic        lk_ready;
    logic [7:0]  lk_octet;
    logic [1:0]  lk_lane;
    logic        lk_frame_start;
    logic        lk_mf_start;

    modport dev  (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, lk_ready,
                  output cfg_rdata, lk_valid, lk_octet, lk_lane, lk_frame_start, lk_mf_start);
    modport host (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, lk_ready,
                  input cfg_rdata, lk_valid, lk_octet, lk_lane, lk_frame_start, lk_mf_start);
endinterface : slbm_if

// ===== core/slbm_host.sv
/*
  slbm_host: receiver end of the byte-mode link. forwards software register
  accesses to the converter end, reads back its answers, counts octets and
  hands the stream to the user with back-pressure.
  assumes: software picks rates and settings; the converter answers reads
  one cycle after the strobe.
*/
`timescale 1ns/1ps
module slbm_host
    import slbm_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // software port
    input  wire logic [15:0] sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata,
    // link
    slbm_if.host             lk,
    // received stream
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic      [7:0]  rx_octet,
    output logic      [1:0]  rx_lane,
    output logic             rx_frame_start,
    output logic             rx_mf_start
);
    // ==========================================================
    // register path; the upper half of the space is the host's own
    logic        host_space;
    logic        sel_host_q;
    logic [7:0]  host_rdata_q;
    logic [15:0] rx_count_q;

    assign host_space   = sw_addr[HOST_SPACE_BIT];
    // rates and pll code are software's choice; writes pass unchanged
    assign lk.cfg_wr    = sw_wr && !host_space;
    assign lk.cfg_rd    = sw_rd && !host_space;
    assign lk.cfg_addr  = sw_addr;
    assign lk.cfg_wdata = sw_wdata;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sel_host_q   <= 1'b0;
            host_rdata_q <= 8'h00;
        end
        else
        begin
            sel_host_q   <= sw_rd && host_space;
            host_rdata_q <= 8'h00;
            if (sw_rd && sw_addr == OFS_HOST_CNT_LO)
                host_rdata_q <= rx_count_q[7:0];
            else if (sw_rd && sw_addr == OFS_HOST_CNT_HI)
                host_rdata_q <= rx_count_q[15:8];
        end
    end
    assign sw_rdata = sel_host_q ? host_rdata_q : lk.cfg_rdata;

    // ==========================================================
    // stream; a stall here fills the converter-end buffer
    assign rx_valid       = lk.lk_valid;
    assign lk.lk_ready    = rx_ready;
    assign rx_octet       = lk.lk_octet;
    assign rx_lane        = lk.lk_lane;
    assign rx_frame_start = lk.lk_frame_start;
    assign rx_mf_start    = lk.lk_mf_start;

    always_ff @(posedge clock)
    begin
        if (srst)
            rx_count_q <= 16'h0000;
        else if (lk.lk_valid && rx_ready)
            rx_count_q <= rx_count_q + 16'h0001;
    end
endmodule : slbm_host

// ===== bench/slbm_chk_sva.sv
/*
  slbm_chk: assertions on the link joining the converter end and the receiver end.
  assumes: instantiated beside the interface, one shared clock, srst active high.
*/
`timescale 1ns/1ps
module slbm_chk
    import slbm_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // register path
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [15:0] cfg_addr,
    input wire logic [7:0]  cfg_wdata,
    input wire logic [7:0]  cfg_rdata,
    // octet stream
    input wire logic        lk_valid,
    input wire logic        lk_ready,
    input wire logic [7:0]  lk_octet,
    input wire logic [1:0]  lk_lane,
    input wire logic        lk_frame_start,
    input wire logic        lk_mf_start
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ====================
    // shadows of written settings
    logic [7:0] pll_q;
    logic [7:0] lanes_q;
    logic [7:0] ctl_q;
    always_ff @(posedge clock)
    begin
        if (srst)
            pll_q <= RST_PLL_LANE_RATE;
        else if (cfg_wr && cfg_addr == OFS_PLL_LANE_RATE)
            pll_q <= cfg_wdata;
    end
    always_ff @(posedge clock)
    begin
        if (srst)
            lanes_q <= RST_LANES;
        else if (cfg_wr && cfg_addr == OFS_LANES)
            lanes_q <= cfg_wdata;
    end
    always_ff @(posedge clock)
    begin
        if (srst)
            ctl_q <= RST_CONTROL;
        else if (cfg_wr && cfg_addr == OFS_CONTROL)
            ctl_q <= cfg_wdata;
    end
    // ====================
    // assertions
    chk_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    chk_pll_read: assert property (cfg_rd && cfg_addr == OFS_PLL_LANE_RATE |=> cfg_rdata == pll_q)
        else $error("pll code read back wrong");
    chk_lanes_read: assert property (cfg_rd && cfg_addr == OFS_LANES |=> cfg_rdata == lanes_q)
        else $error("lane count read back wrong");
    chk_hold_word: assert property (lk_valid && !lk_ready && !cfg_wr && !$past(cfg_wr)
        && !$past(cfg_wr, 2) |=> lk_valid && $stable(lk_octet) && $stable(lk_lane))
        else $error("stalled word not held");
    chk_mf_in_frame: assert property (lk_valid && lk_mf_start |-> lk_frame_start)
        else $error("multiframe start outside frame start");
    chk_lane_range: assert property (lk_valid |-> {6'h00, lk_lane} < lanes_q)
        else $error("lane index beyond lane count");
    chk_valid_reset: assert property ($fell(srst) |-> !lk_valid)
        else $error("word present after reset");
    chk_flush_off: assert property (!ctl_q[CTL_LINK_EN] && !$past(ctl_q[CTL_LINK_EN])
        |-> !lk_valid)
        else $error("word sent with link disabled");
    // ====================
    // covers
    cover property (lk_valid && lk_ready && lk_mf_start);
    cover property (lk_valid && !lk_ready);
    cover property (cfg_rd ##1 cfg_rdata != 8'h00);
endmodule : slbm_chk

// ===== bench/serial_link_byte_mode_config_tb_top.sv
/*
  testbench: both link ends joined by slbm_if, driven on the software port and sample side.
  assumes: 40 MHz clock, srst held 8 cycles, stimulus by non-blocking assignment at posedge.
*/
`timescale 1ns/1ps
module serial_link_byte_mode_config_tb_top;
    import slbm_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] sw_addr = 16'h0000;
    logic [7:0]  sw_wdata = 8'h00;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [7:0]  sw_rdata;
    logic        sample_valid = 1'b0;
    logic [7:0]  sample_data = 8'h00;
    logic        sample_ctrl = 1'b0;
    logic        sample_ready;
    logic        config_error;
    logic        rx_valid;
    logic        rx_ready = 1'b1;
    logic [7:0]  rx_octet;
    logic [1:0]  rx_lane;
    logic        rx_frame_start;
    logic        rx_mf_start;
    logic [11:0] got [$];
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;
    slbm_if slbm_if_i ();
    slbm_dev slbm_dev_i (.clock(clock), .srst(srst), .lk(slbm_if_i),
        .sample_valid(sample_valid), .sample_data(sample_data), .sample_ctrl(sample_ctrl),
        .sample_ready(sample_ready), .config_error(config_error));
    slbm_host slbm_host_i (.clock(clock), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lk(slbm_if_i), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_octet(rx_octet), .rx_lane(rx_lane),
        .rx_frame_start(rx_frame_start), .rx_mf_start(rx_mf_start));
    slbm_chk slbm_chk_i (.clock(clock), .srst(srst),
        .cfg_wr(slbm_if_i.cfg_wr), .cfg_rd(slbm_if_i.cfg_rd), .cfg_addr(slbm_if_i.cfg_addr),
        .cfg_wdata(slbm_if_i.cfg_wdata), .cfg_rdata(slbm_if_i.cfg_rdata),
        .lk_valid(slbm_if_i.lk_valid), .lk_ready(slbm_if_i.lk_ready),
        .lk_octet(slbm_if_i.lk_octet), .lk_lane(slbm_if_i.lk_lane),
        .lk_frame_start(slbm_if_i.lk_frame_start), .lk_mf_start(slbm_if_i.lk_mf_start));
    initial
    begin
        forever #12.5 clock = ~clock;
    end
    // ====================
    // monitor and timeout
    always @(posedge clock)
    begin
        if (rx_valid && rx_ready)
            got.push_back({rx_mf_start, rx_frame_start, rx_lane, rx_octet});
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            stop_test();
        end
    end
    // ====================
    // shared tasks
    task check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clock);
        sw_wr <= 1'b0;
    endtask : wr
    task rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clock);
        sw_rd <= 1'b0;
        #1 check({4'h0, sw_rdata}, {4'h0, e});
    endtask : rdc
    task err_is(input logic e);
        repeat (3) @(posedge clock);
        #1 check(12'(config_error), 12'(e));
    endtask : err_is
    // holds sample_valid across words so the strobe is never written twice in one step
    task send(input int n, input logic [7:0] base);
        logic rdy;
        @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
            sample_valid <= 1'b1;
            sample_data <= base + i[7:0];
            do
            begin
                @(negedge clock);
                rdy = sample_ready;
                @(posedge clock);
            end while (!rdy);
        end
        sample_valid <= 1'b0;
    endtask : send
    task stop_test();
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // ====================
    // scenarios
    task t_reset();
        logic [15:0] a [12];
        logic [7:0]  e [12];
        a = '{OFS_PLL_LANE_RATE, OFS_LANES, OFS_CONVERTERS, OFS_OCTETS_FRAME, OFS_FRAMES_MF,
              OFS_DECIMATION, OFS_BAND, OFS_CONTROL, OFS_RESOLUTION, OFS_STATUS, 16'h0599,
              OFS_HOST_CNT_LO};
        e = '{RST_PLL_LANE_RATE, RST_LANES, RST_CONVERTERS, RST_OCTETS_FRAME, RST_FRAMES_MF,
              RST_DECIMATION, 8'h02, RST_CONTROL, RST_RESOLUTION, 8'h01, 8'h00, 8'h00};
        for (int i = 0; i < 12; i++)
            rdc(a[i], e[i]);
        wr(OFS_STATUS, 8'hff);
        rdc(OFS_STATUS, 8'h01);
    endtask : t_reset
    task t_stream();
        wr(OFS_CONTROL, 8'h01);
        rdc(OFS_STATUS, 8'h03);
        got.delete();
        send(3, 8'ha0);
        repeat (3) @(posedge clock);
        check(12'(got.size()), 12'h003);
        for (int i = 0; i < 3; i++)
            check(got[i], {(i == 0), 1'b1, 2'b00, 8'ha0 + i[7:0]});
        rdc(OFS_HOST_CNT_LO, 8'h03);
    endtask : t_stream
    task t_decim();
        wr(OFS_DECIMATION, 8'h02);
        got.delete();
        send(4, 8'hb0);
        repeat (3) @(posedge clock);
        check(12'(got.size()), 12'h002);
        check(got[1], 12'h4b2);
        rdc(OFS_HOST_CNT_LO, 8'h05);
    endtask : t_decim
    task t_stall();
        wr(OFS_DECIMATION, 8'h01);
        wr(OFS_LANES, 8'h02);
        wr(OFS_RESOLUTION, 8'h07);
        rx_ready <= 1'b0;
        got.delete();
        send(2, 8'hc3);
        repeat (3) @(posedge clock);
        #1 check({11'h0, rx_valid}, 12'h001);
        @(posedge clock);
        rx_ready <= 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 2; i++)
            check(got[i] & 12'h7ff, {2'b01, i[1:0], (8'hc3 + i[7:0]) & 8'hfe});
    endtask : t_stall
    task t_illegal();
        logic [15:0] a [6];
        logic [7:0]  bad [6];
        logic [7:0]  good [6];
        a = '{OFS_FRAMES_MF, OFS_LANES, OFS_DECIMATION, OFS_BAND, OFS_OCTETS_FRAME,
              OFS_PLL_LANE_RATE};
        bad = '{8'h10, 8'h03, 8'h03, 8'h03, 8'h03, 8'h50};
        good = '{8'h20, 8'h02, 8'h01, 8'h02, 8'h01, 8'h10};
        for (int i = 0; i < 6; i++)
        begin
            wr(a[i], bad[i]);
            err_is(1'b1);
            check({11'h0, sample_ready}, 12'h000);
            rdc(OFS_STATUS, 8'h00);
            wr(a[i], good[i]);
            err_is(1'b0);
        end
        wr(OFS_PLL_LANE_RATE, 8'h50);
        wr(OFS_BAND, 8'h00);
        err_is(1'b0);
        wr(OFS_PLL_LANE_RATE, 8'h30);
        wr(OFS_BAND, 8'h03);
        err_is(1'b0);
        wr(OFS_PLL_LANE_RATE, 8'h10);
        wr(OFS_BAND, 8'h02);
        err_is(1'b0);
    endtask : t_illegal
    initial
    begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_stream();
        t_decim();
        t_stall();
        t_illegal();
        stop_test();
    end
endmodule : serial_link_byte_mode_config_tb_top
